/* pkg/ofr_pkg.sv */
// Constants, field layouts and state codes for the offset programming and retransmit FIFO core.
// Assumes one clock at 100 MHz; all users write ofr_pkg::name.
//
// Behaviour
// - Both buses nine bits: six offset writes load every offset register.
// - Eighteen-bit input takes four offset writes, nine-bit input takes six.
// - Offset-load and write enable low store data into next offset part.
// - Nine-bit input needs one extra write per offset register.
// - Write and read offset pointers advance independently; host avoids simultaneous use.
// - Master reset returns both offset pointers to empty low; partial keeps them.
// - Memory writes may interleave programming; pausing resumes at next offset part.
// - Flag invalid until its offset written, then valid three edges later.
// - Offset-load and read enable low put selected offset part on outputs.
// - Offset read-back takes four reads on eighteen-bit output, six on nine-bit.
// - Offset reads go empty parts, then full parts, then wrap around.
// - Interrupted offset reads resume where they stopped.
// - Normal-latency retransmit low on a clock edge starts setup, read pointer to zero.
// - Standard mode usable depth is the memory depth.
// - Fall-through mode usable depth is one word larger.
// - Standard mode: empty flag low during setup, every read needs read enable.
// - Fall-through: output-valid flag high during setup, first word falls through.
// - Half-full updates on the retransmit edge, almost-empty two edges later.
// - Zero latency puts first word in output register on the retransmit edge.
// - Parallel or serial programming choice captured only at master reset.
package ofr_pkg;

	localparam int DATA_W = 18;
	localparam int ADDR_W = 17;
	localparam int CNT_W = 18;
	localparam int OFS_W = 18;
	localparam logic [CNT_W-1:0] MEM_DEPTH = 18'h2_0000;
	localparam logic [CNT_W-1:0] HALF_DEPTH = 18'h1_0000;

	// Offset slot counts per input or output width
	localparam logic [2:0] SLOTS_X18 = 3'h4;
	localparam logic [2:0] SLOTS_X9 = 3'h6;
	localparam logic [1:0] PARTS_X18 = 2'h2;
	localparam logic [1:0] PARTS_X9 = 2'h3;

	// Part layouts: x18 parts are 16 then 2 bits wide, x9 parts are 8, 8 then 2 bits wide
	localparam int PART_X18_W = 16;
	localparam int PART_X9_W = 8;

	localparam logic [OFS_W-1:0] EMPTY_OFS_RST = 18'h0_007F;
	localparam logic [OFS_W-1:0] FULL_OFS_RST = 18'h0_007F;

	// Programmable flags settle this many edges after a pointer moves, three edges after an offset write
	localparam int FLAG_SYNC_EDGES = 2;

	localparam int CLK_PERIOD_NS = 10;
	localparam int RT_SETUP_NS = 30;
	localparam int RT_SETUP_CYC = (RT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] RT_SETUP_LAST = 4'(RT_SETUP_CYC - 1);

	typedef enum logic [0:0] {
		RT_IDLE = 1'b0,
		RT_SETUP = 1'b1
	} ofr_rt_state_t;

endpackage

/* logic/ofr_skid_buf.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes an asynchronous active-low reset and a synchronous flush that empties it.
`timescale 1ns/1ps
module ofr_skid_buf #(
	parameter int W = 19
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);

	logic [W-1:0] mem_q [2];
	logic [W-1:0] mem_d [2];
	logic wp_q, wp_d, rp_q, rp_d;
	logic [1:0] cnt_q, cnt_d;
	logic push, pop;

	assign o_ready = cnt_q != 2'h2;
	assign o_valid = cnt_q != 2'h0;
	assign o_data = mem_q[rp_q];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	always_comb begin
		mem_d = mem_q;
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wp_q] = i_data;
			wp_d = !wp_q;
		end
		if (pop) begin
			rp_d = !rp_q;
		end
		cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
		if (i_flush) begin
			wp_d = 1'b0;
			rp_d = 1'b0;
			cnt_d = 2'h0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			mem_q <= mem_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

endmodule

/* logic/ofr_fifo_ctrl.sv */
// FIFO core with parallel offset programming, offset read-back and retransmit.
// Assumes write and read sides share i_clock; all pins except the asynchronous i_nrst are synchronous to it.
`timescale 1ns/1ps
module ofr_fifo_ctrl (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_master_reset_n,
	input wire logic i_partial_reset_n,
	input wire logic i_first_word_fallthrough_mode,
	input wire logic i_retransmit_latency_sel,
	input wire logic i_parallel_prog_sel,
	input wire logic i_in_width_x9,
	input wire logic i_out_width_x9,
	input wire logic i_offset_load_n,
	input wire logic i_write_en_n,
	input wire logic i_read_en_n,
	input wire logic i_retransmit_req_n,
	input wire logic [ofr_pkg::DATA_W-1:0] i_data_in_bus,
	output logic [ofr_pkg::DATA_W-1:0] o_data_out_bus,
	output logic o_empty_flag_n,
	output logic o_output_ready_n,
	output logic o_full_flag_n,
	output logic o_input_ready_n,
	output logic o_half_full_flag_n,
	output logic o_prog_almost_empty_n,
	output logic o_prog_almost_full_n
);

	// --------------------------------------------------------------
	// Reset release
	// --------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// --------------------------------------------------------------
	// Offset part helpers
	// --------------------------------------------------------------
	function automatic logic [ofr_pkg::OFS_W-1:0] ofs_insert(input logic [ofr_pkg::OFS_W-1:0] old,
			input logic [1:0] part, input logic x9, input logic [ofr_pkg::DATA_W-1:0] din);
		logic [ofr_pkg::OFS_W-1:0] r;
		r = old;
		if (x9) begin
			unique case (part)
				2'h0: r[7:0] = din[7:0];
				2'h1: r[15:8] = din[7:0];
				default: r[17:16] = din[1:0];
			endcase
		end else begin
			if (part == 2'h0) begin
				r[15:0] = din[15:0];
			end else begin
				r[17:16] = din[1:0];
			end
		end
		return r;
	endfunction

	function automatic logic [ofr_pkg::DATA_W-1:0] ofs_extract(input logic [ofr_pkg::OFS_W-1:0] v,
			input logic [1:0] part, input logic x9);
		logic [ofr_pkg::DATA_W-1:0] r;
		r = '0;
		if (x9) begin
			unique case (part)
				2'h0: r[7:0] = v[7:0];
				2'h1: r[7:0] = v[15:8];
				default: r[1:0] = v[17:16];
			endcase
		end else begin
			if (part == 2'h0) begin
				r[15:0] = v[15:0];
			end else begin
				r[1:0] = v[17:16];
			end
		end
		return r;
	endfunction

	// --------------------------------------------------------------
	// Write-side buffer
	// --------------------------------------------------------------
	// Entry carries the offset-load level beside the word, so a stall never mixes the two targets
	logic buf_ready, buf_valid, buf_pop;
	logic [ofr_pkg::DATA_W:0] buf_data;
	logic buf_to_ofs;
	logic soft_rst;

	ofr_skid_buf #(.W(ofr_pkg::DATA_W + 1)) u_wbuf (
		.i_clock(i_clock),
		.i_rst_n(rst_n),
		.i_flush(soft_rst),
		.i_valid(!i_write_en_n),
		.o_ready(buf_ready),
		.i_data({i_offset_load_n, i_data_in_bus}),
		.o_valid(buf_valid),
		.i_ready(buf_pop),
		.o_data(buf_data)
	);
	assign buf_to_ofs = !buf_data[ofr_pkg::DATA_W];

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	logic [ofr_pkg::DATA_W-1:0] mem [2**ofr_pkg::ADDR_W];
	logic first_word_fallthrough_mode_q, first_word_fallthrough_mode_d, zero_lat_q, zero_lat_d, par_q, par_d, in9_q, in9_d, out9_q, out9_d;
	logic [ofr_pkg::OFS_W-1:0] e_ofs_q, e_ofs_d, f_ofs_q, f_ofs_d;
	logic [2:0] wslot_q, wslot_d, rslot_q, rslot_d;
	logic [ofr_pkg::CNT_W-1:0] wptr_q, wptr_d, rptr_q, rptr_d, cnt_d;
	logic [ofr_pkg::DATA_W-1:0] dout_q, dout_d;
	logic orv_q, orv_d, ef_n_q, ef_n_d, hf_n_q, hf_n_d;
	logic e_ok_q, e_ok_d, f_ok_q, f_ok_d;
	logic [1:0] e_vld_q, e_vld_d, f_vld_q, f_vld_d, pae_p_q, pae_p_d, paf_p_q, paf_p_d;
	logic pae_q, pae_d, paf_q, paf_d;
	ofr_pkg::ofr_rt_state_t rt_q, rt_d;
	logic [3:0] rt_cnt_q, rt_cnt_d;
	logic mem_we, rt_start, mem_full, ofs_rd, rd_go;
	logic [1:0] wpart, rpart;
	logic wsel_full, rsel_full;

	assign soft_rst = !i_master_reset_n || !i_partial_reset_n;
	// Fall-through keeps one more word in the output register beyond this limit
	assign mem_full = (wptr_q - rptr_q) == ofr_pkg::MEM_DEPTH;
	// Offset words are always drained; memory words wait for space and for setup to end
	assign buf_pop = !soft_rst && buf_valid && (buf_to_ofs || (!mem_full && rt_q == ofr_pkg::RT_IDLE));
	assign mem_we = buf_pop && !buf_to_ofs;
	assign rt_start = !i_retransmit_req_n && rt_q == ofr_pkg::RT_IDLE;
	assign ofs_rd = !i_offset_load_n && !i_read_en_n;

	always_comb begin
		wsel_full = in9_q ? (wslot_q >= 3'h3) : (wslot_q >= 3'h2);
		wpart = in9_q ? 2'(wsel_full ? wslot_q - 3'h3 : wslot_q) : 2'(wslot_q[0]);
		rsel_full = out9_q ? (rslot_q >= 3'h3) : (rslot_q >= 3'h2);
		rpart = out9_q ? 2'(rsel_full ? rslot_q - 3'h3 : rslot_q) : 2'(rslot_q[0]);
	end

	// --------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------
	always_comb begin
		first_word_fallthrough_mode_d = first_word_fallthrough_mode_q;
		zero_lat_d = zero_lat_q;
		par_d = par_q;
		in9_d = in9_q;
		out9_d = out9_q;
		e_ofs_d = e_ofs_q;
		f_ofs_d = f_ofs_q;
		wslot_d = wslot_q;
		rslot_d = rslot_q;
		wptr_d = wptr_q;
		rptr_d = rptr_q;
		dout_d = dout_q;
		orv_d = orv_q;
		e_ok_d = e_ok_q;
		f_ok_d = f_ok_q;
		rt_d = rt_q;
		rt_cnt_d = rt_cnt_q;
		rd_go = 1'b0;

		// Offset programming through the buffer
		if (buf_pop && buf_to_ofs && par_q) begin
			if (wsel_full) begin
				f_ofs_d = ofs_insert(f_ofs_q, wpart, in9_q, buf_data[ofr_pkg::DATA_W-1:0]);
				f_ok_d = wpart == (in9_q ? 2'h2 : 2'h1);
				if (wpart == 2'h0) begin
					f_ok_d = 1'b0;
				end
			end else begin
				e_ofs_d = ofs_insert(e_ofs_q, wpart, in9_q, buf_data[ofr_pkg::DATA_W-1:0]);
				e_ok_d = wpart == (in9_q ? 2'h2 : 2'h1);
			end
			// Full wrap after the last slot; pauses simply leave the slot pointer in place
			wslot_d = (wslot_q == (in9_q ? ofr_pkg::SLOTS_X9 : ofr_pkg::SLOTS_X18) - 3'h1) ? 3'h0 :
				3'(wslot_q + 3'h1);
		end
		if (mem_we) begin
			wptr_d = 18'(wptr_q + 18'h0_0001);
		end

		// Read side
		if (rt_start) begin
			if (zero_lat_q) begin
				dout_d = mem[0];
				rptr_d = 18'h0_0001;
				orv_d = 1'b1;
			end else begin
				rptr_d = '0;
				orv_d = 1'b0;
				rt_d = ofr_pkg::RT_SETUP;
				rt_cnt_d = '0;
			end
		end else if (rt_q == ofr_pkg::RT_SETUP) begin
			rt_cnt_d = 4'(rt_cnt_q + 4'h1);
			if (rt_cnt_q == ofr_pkg::RT_SETUP_LAST) begin
				rt_d = ofr_pkg::RT_IDLE;
				if (first_word_fallthrough_mode_q && wptr_q != rptr_q) begin
					dout_d = mem[rptr_q[ofr_pkg::ADDR_W-1:0]];
					rptr_d = 18'(rptr_q + 18'h0_0001);
					orv_d = 1'b1;
				end
			end
		end else if (ofs_rd) begin
			dout_d = ofs_extract(rsel_full ? f_ofs_q : e_ofs_q, rpart, out9_q);
			rslot_d = (rslot_q == (out9_q ? ofr_pkg::SLOTS_X9 : ofr_pkg::SLOTS_X18) - 3'h1) ? 3'h0 :
				3'(rslot_q + 3'h1);
		end else if (i_offset_load_n) begin
			// Standard mode needs read enable for every word; fall-through loads on its own
			if (first_word_fallthrough_mode_q) begin
				rd_go = (!orv_q || !i_read_en_n) && wptr_q != rptr_q;
				if (orv_q && !i_read_en_n && wptr_q == rptr_q) begin
					orv_d = 1'b0;
				end
			end else begin
				rd_go = !i_read_en_n && wptr_q != rptr_q;
			end
			if (rd_go) begin
				dout_d = mem[rptr_q[ofr_pkg::ADDR_W-1:0]];
				rptr_d = 18'(rptr_q + 18'h0_0001);
				orv_d = 1'b1;
			end
		end

		// Master reset catches straps and rewinds offsets; partial keeps them
		if (!i_master_reset_n) begin
			first_word_fallthrough_mode_d = i_first_word_fallthrough_mode;
			zero_lat_d = !i_retransmit_latency_sel;
			par_d = i_parallel_prog_sel;
			in9_d = i_in_width_x9;
			out9_d = i_out_width_x9;
			e_ofs_d = ofr_pkg::EMPTY_OFS_RST;
			f_ofs_d = ofr_pkg::FULL_OFS_RST;
			wslot_d = 3'h0;
			rslot_d = 3'h0;
			e_ok_d = 1'b1;
			f_ok_d = 1'b1;
		end
		if (soft_rst) begin
			wptr_d = '0;
			rptr_d = '0;
			dout_d = '0;
			orv_d = 1'b0;
			rt_d = ofr_pkg::RT_IDLE;
			rt_cnt_d = '0;
		end
	end

	// --------------------------------------------------------------
	// Flags
	// --------------------------------------------------------------
	always_comb begin
		cnt_d = 18'(wptr_d - rptr_d);
		// Half-full follows the new pointers on the same edge
		hf_n_d = !(cnt_d > ofr_pkg::HALF_DEPTH);
		ef_n_d = (cnt_d != '0) && rt_d == ofr_pkg::RT_IDLE;
		e_vld_d = {e_vld_q[0], e_ok_q};
		f_vld_d = {f_vld_q[0], f_ok_q};
		// Two-stage pipes give the required two-edge lag of the programmable flags
		pae_p_d = {pae_p_q[0], cnt_d > e_ofs_q};
		paf_p_d = {paf_p_q[0], !(cnt_d >= 18'(ofr_pkg::MEM_DEPTH - f_ofs_q))};
		pae_d = (e_vld_q[1] && e_ok_q) ? pae_p_q[1] : pae_q;
		paf_d = (f_vld_q[1] && f_ok_q) ? paf_p_q[1] : paf_q;
		if (soft_rst) begin
			hf_n_d = 1'b1;
			ef_n_d = 1'b0;
			pae_p_d = 2'b00;
			paf_p_d = 2'b11;
			pae_d = 1'b0;
			paf_d = 1'b1;
		end
	end

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (mem_we) begin
			mem[wptr_q[ofr_pkg::ADDR_W-1:0]] <= buf_data[ofr_pkg::DATA_W-1:0];
		end
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			first_word_fallthrough_mode_q <= 1'b0;
			zero_lat_q <= 1'b0;
			par_q <= 1'b1;
			in9_q <= 1'b0;
			out9_q <= 1'b0;
			e_ofs_q <= ofr_pkg::EMPTY_OFS_RST;
			f_ofs_q <= ofr_pkg::FULL_OFS_RST;
			wslot_q <= 3'h0;
			rslot_q <= 3'h0;
			wptr_q <= '0;
			rptr_q <= '0;
			dout_q <= '0;
			orv_q <= 1'b0;
			ef_n_q <= 1'b0;
			hf_n_q <= 1'b1;
			e_ok_q <= 1'b1;
			f_ok_q <= 1'b1;
			e_vld_q <= 2'b11;
			f_vld_q <= 2'b11;
			pae_p_q <= 2'b00;
			paf_p_q <= 2'b11;
			pae_q <= 1'b0;
			paf_q <= 1'b1;
			rt_q <= ofr_pkg::RT_IDLE;
			rt_cnt_q <= '0;
		end else begin
			first_word_fallthrough_mode_q <= first_word_fallthrough_mode_d;
			zero_lat_q <= zero_lat_d;
			par_q <= par_d;
			in9_q <= in9_d;
			out9_q <= out9_d;
			e_ofs_q <= e_ofs_d;
			f_ofs_q <= f_ofs_d;
			wslot_q <= wslot_d;
			rslot_q <= rslot_d;
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			dout_q <= dout_d;
			orv_q <= orv_d;
			ef_n_q <= ef_n_d;
			hf_n_q <= hf_n_d;
			e_ok_q <= e_ok_d;
			f_ok_q <= f_ok_d;
			e_vld_q <= e_vld_d;
			f_vld_q <= f_vld_d;
			pae_p_q <= pae_p_d;
			paf_p_q <= paf_p_d;
			pae_q <= pae_d;
			paf_q <= paf_d;
			rt_q <= rt_d;
			rt_cnt_q <= rt_cnt_d;
		end
	end

	assign o_data_out_bus = dout_q;
	assign o_empty_flag_n = ef_n_q;
	assign o_output_ready_n = !orv_q;
	assign o_full_flag_n = buf_ready;
	assign o_input_ready_n = !buf_ready;
	assign o_half_full_flag_n = hf_n_q;
	assign o_prog_almost_empty_n = pae_q;
	assign o_prog_almost_full_n = paf_q;

endmodule

/* verif/ofr_host_model.sv */
// Host write controller: streams bursts of words into the FIFO write port.
// Assumes the bench sets the offset-load select before each burst.
`timescale 1ns/1ps
module ofr_host_model (
	input wire logic i_clock,
	input wire logic i_go,
	input wire logic [17:0] i_base,
	input wire logic [7:0] i_count,
	input wire logic i_ready_n,
	output logic o_write_en_n,
	output logic [17:0] o_data,
	output logic o_busy
);
	logic [7:0] left_q;
	initial begin
		o_write_en_n = 1'b1;
		o_data = 18'h0_0000;
		o_busy = 1'b0;
		left_q = 8'h00;
	end
	// Write enable idles high, so a retransmit never meets a pending write
	always @(posedge i_clock) begin
		if (i_go && !o_busy) begin
			o_busy <= 1'b1;
			o_write_en_n <= 1'b0;
			o_data <= i_base;
			left_q <= i_count - 8'h01;
		end else if (o_busy && !i_ready_n) begin // Word held until taken
			if (left_q == 8'h00) begin
				o_busy <= 1'b0;
				o_write_en_n <= 1'b1;
				o_data <= ~o_data; // Released bus must not show a stale word
			end else begin
				left_q <= left_q - 8'h01;
				o_data <= o_data + 18'h0_0001;
			end
		end
	end
endmodule

/* verif/ofr_fifo_checker.sv */
// Assertions on the offset and retransmit FIFO top ports.
// Assumes straps only count once a master reset has captured them.
`timescale 1ns/1ps
module ofr_fifo_checker (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_master_reset_n,
	input wire logic i_partial_reset_n,
	input wire logic i_first_word_fallthrough_mode,
	input wire logic i_retransmit_latency_sel,
	input wire logic i_offset_load_n,
	input wire logic i_write_en_n,
	input wire logic i_read_en_n,
	input wire logic i_retransmit_req_n,
	input wire logic [ofr_pkg::DATA_W-1:0] i_data_in_bus,
	input wire logic [ofr_pkg::DATA_W-1:0] o_data_out_bus,
	input wire logic o_empty_flag_n,
	input wire logic o_output_ready_n,
	input wire logic o_full_flag_n,
	input wire logic o_input_ready_n,
	input wire logic o_half_full_flag_n,
	input wire logic o_prog_almost_empty_n,
	input wire logic o_prog_almost_full_n
);
	// ----
	// Helper state
	// ----
	logic first_word_fallthrough_mode_q, rm_q, got_q, rst_ok;
	logic [ofr_pkg::DATA_W-1:0] first_q;
	assign rst_ok = i_master_reset_n && i_partial_reset_n;
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			first_word_fallthrough_mode_q <= 1'b0;
			rm_q <= 1'b1;
			got_q <= 1'b0;
			first_q <= 18'h0_0000;
		end else begin
			if (!i_master_reset_n) begin
				first_word_fallthrough_mode_q <= i_first_word_fallthrough_mode;
				rm_q <= i_retransmit_latency_sel;
			end
			// First memory word after a reset is what a retransmit must replay
			if (!rst_ok) begin
				got_q <= 1'b0;
			end else if (!got_q && !i_write_en_n && !o_input_ready_n && i_offset_load_n) begin
				got_q <= 1'b1;
				first_q <= i_data_in_bus;
			end
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	a_mrst_flags: assert property (!i_master_reset_n |=> o_data_out_bus == 18'h0_0000
		&& !o_prog_almost_empty_n && o_prog_almost_full_n && o_half_full_flag_n)
		else $error("master reset outputs wrong");
	a_prst_flags: assert property (!i_partial_reset_n && i_master_reset_n |=> o_data_out_bus == 18'h0_0000
		&& !o_prog_almost_empty_n && (first_word_fallthrough_mode_q ? o_output_ready_n : !o_empty_flag_n))
		else $error("partial reset outputs wrong");
	a_std_read_gate: assert property (!first_word_fallthrough_mode_q && i_read_en_n && i_retransmit_req_n && rst_ok
		|=> $stable(o_data_out_bus)) else $error("output moved without read enable");
	a_rt_setup_low: assert property (!first_word_fallthrough_mode_q && rm_q && !i_retransmit_req_n
		|=> !o_empty_flag_n [*2]) else $error("empty flag not low in setup");
	a_rt_setup_done: assert property (!first_word_fallthrough_mode_q && rm_q && !i_retransmit_req_n
		|=> ##[2:8] o_empty_flag_n) else $error("setup never completed");
	a_first_word_fallthrough_mode_rt_word: assert property (first_word_fallthrough_mode_q && rm_q && !i_retransmit_req_n && got_q |=> o_output_ready_n
		##[1:8] (!o_output_ready_n && o_data_out_bus == first_q)) else $error("first word not presented");
	a_zero_lat_word: assert property (!rm_q && !i_retransmit_req_n && got_q && rst_ok
		|=> o_data_out_bus == first_q) else $error("zero latency word missing");
	a_ready_flag: assert property (o_input_ready_n != o_full_flag_n)
		else $error("ready and full disagree");
	c_rt_std: cover property (!i_retransmit_req_n && !first_word_fallthrough_mode_q && rm_q);
	c_rt_first_word_fallthrough_mode: cover property (!i_retransmit_req_n && first_word_fallthrough_mode_q);
	c_ofs_rd: cover property (!i_offset_load_n && !i_read_en_n);
endmodule

bind ofr_fifo_ctrl ofr_fifo_checker u_chk (
	.i_clock(i_clock),
	.i_nrst(i_nrst),
	.i_master_reset_n(i_master_reset_n),
	.i_partial_reset_n(i_partial_reset_n),
	.i_first_word_fallthrough_mode(i_first_word_fallthrough_mode),
	.i_retransmit_latency_sel(i_retransmit_latency_sel),
	.i_offset_load_n(i_offset_load_n),
	.i_write_en_n(i_write_en_n),
	.i_read_en_n(i_read_en_n),
	.i_retransmit_req_n(i_retransmit_req_n),
	.i_data_in_bus(i_data_in_bus),
	.o_data_out_bus(o_data_out_bus),
	.o_empty_flag_n(o_empty_flag_n),
	.o_output_ready_n(o_output_ready_n),
	.o_full_flag_n(o_full_flag_n),
	.o_input_ready_n(o_input_ready_n),
	.o_half_full_flag_n(o_half_full_flag_n),
	.o_prog_almost_empty_n(o_prog_almost_empty_n),
	.o_prog_almost_full_n(o_prog_almost_full_n)
);

/* verif/tb.sv */
// Self-checking bench: offset load and read-back, retransmit in standard, standard zero-latency and fall-through modes.
// Assumes the host write model and the bound checker.
`timescale 1ns/1ps
module tb;
	typedef struct packed {logic [17:0] d; logic [17:0] m;} ofr_row_t;
	logic i_clock = 0, i_nrst = 0, mrst_n = 1, prst_n = 1, first_word_fallthrough_mode = 0, rm = 1, x9 = 0;
	logic ld_n = 1, ren_n = 1, rt_n = 1, go = 0, busy, wen_n, ef_n, or_n, full_n, rdy_n, saw_full = 0;
	logic [17:0] base = 18'h0_0000, wd, q;
	logic [7:0] cnt = 8'h01;
	int err_total = 0, n_checks = 0, k, s, n;
	ofr_row_t rows [10] = '{'{18'h0_00A5, 18'h0_FFFF}, '{18'h3_FFFE, 18'h0_0003},
		'{18'h0_5A3C, 18'h0_FFFF}, '{18'h0_0001, 18'h0_0003}, '{18'h0_005A, 18'h0_00FF},
		'{18'h0_00C3, 18'h0_00FF}, '{18'h0_0002, 18'h0_0003}, '{18'h0_0011, 18'h0_00FF},
		'{18'h0_0022, 18'h0_00FF}, '{18'h0_0001, 18'h0_0003}};
	always #5 i_clock = ~i_clock;
	always @(posedge i_clock) if (full_n === 1'b0) saw_full = 1'b1;
	ofr_fifo_ctrl dut (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_master_reset_n(mrst_n),
		.i_partial_reset_n(prst_n),
		.i_first_word_fallthrough_mode(first_word_fallthrough_mode),
		.i_retransmit_latency_sel(rm),
		.i_parallel_prog_sel(1'b1),
		.i_in_width_x9(x9),
		.i_out_width_x9(x9),
		.i_offset_load_n(ld_n),
		.i_write_en_n(wen_n),
		.i_read_en_n(ren_n),
		.i_retransmit_req_n(rt_n),
		.i_data_in_bus(wd),
		.o_data_out_bus(q),
		.o_empty_flag_n(ef_n),
		.o_output_ready_n(or_n),
		.o_full_flag_n(full_n),
		.o_input_ready_n(rdy_n),
		.o_half_full_flag_n(),
		.o_prog_almost_empty_n(),
		.o_prog_almost_full_n()
	);
	ofr_host_model host (
		.i_clock(i_clock),
		.i_go(go),
		.i_base(base),
		.i_count(cnt),
		.i_ready_n(rdy_n),
		.o_write_en_n(wen_n),
		.o_data(wd),
		.o_busy(busy)
	);
	task chk(input string nm, input logic [17:0] sn, input logic [17:0] ex);
		n_checks++;
		if (sn !== ex) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, ex, sn);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task mreset(input logic f, input logic r, input logic w);
		@(posedge i_clock);
		first_word_fallthrough_mode <= f;
		rm <= r;
		x9 <= w;
		mrst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		mrst_n <= 1'b1;
	endtask
	task start(input logic [17:0] b, input logic [7:0] c, input logic l);
		ld_n <= l;
		base <= b;
		cnt <= c;
		go <= 1'b1;
	endtask
	task drain;
		@(posedge i_clock);
		go <= 1'b0;
		k = 0;
		do begin
			@(posedge i_clock);
			k++;
		end while (busy === 1'b1 && k < 60);
		chk("drain", 18'(busy), 18'h0_0000);
	endtask
	task wr(input logic [17:0] b, input logic [7:0] c, input logic l);
		@(posedge i_clock);
		start(b, c, l);
		drain;
	endtask
	task rd(input logic l);
		@(posedge i_clock);
		ld_n <= l;
		ren_n <= 1'b0; // Never while the write model is busy
		@(posedge i_clock);
		ren_n <= 1'b1;
		ld_n <= 1'b1;
		#1;
	endtask
	task readn(input logic [17:0] b, input int c);
		for (int i = 0; i < c; i++) begin
			rd(1'b1);
			chk("word", q, b + 18'(i));
		end
	endtask
	task rtx(input logic w);
		@(posedge i_clock);
		rt_n <= 1'b0;
		@(posedge i_clock);
		rt_n <= 1'b1;
		if (w) start(18'h0_0200, 8'h04, 1'b1);
		#1;
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		repeat (5) @(posedge i_clock);
		i_nrst <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			s = p * 4;
			n = p ? 6 : 4;
			mreset(1'b0, 1'b1, p[0]);
			for (int i = s; i < s + n; i++) begin
				wr(rows[i].d, 8'h01, 1'b0);
				if (i == s) wr(18'h0_0055, 8'h02, 1'b1);
			end
			for (int i = s; i <= s + n; i++) begin
				rd(1'b0);
				k = (i == s + n) ? s : i;
				chk("offset", q & rows[k].m, rows[k].d & rows[k].m);
				if (i == s) rd(1'b1);
				if (i == s) chk("memory", q, 18'h0_0055);
			end
		end
		mreset(1'b0, 1'b1, 1'b0);
		rd(1'b0);
		chk("default", q & 18'h0_FFFF, 18'h0_007F);
		@(posedge i_clock);
		prst_n <= 1'b0;
		@(posedge i_clock);
		prst_n <= 1'b1;
		rd(1'b0);
		rd(1'b0);
		chk("kept", q & 18'h0_FFFF, 18'h0_007F);
		mreset(1'b0, 1'b1, 1'b0);
		wr(18'h0_0100, 8'h04, 1'b1);
		readn(18'h0_0100, 3);
		chk("ready", 18'(ef_n), 18'h0_0001);
		rtx(1'b1);
		chk("setup", 18'(ef_n), 18'h0_0000);
		drain;
		chk("stall", 18'(saw_full), 18'h0_0001);
		for (k = 0; k < 12 && ef_n !== 1'b1; k++) @(posedge i_clock);
		chk("ef wait", 18'(ef_n), 18'h0_0001);
		readn(18'h0_0100, 2);
		mreset(1'b0, 1'b0, 1'b0);
		wr(18'h0_0300, 8'h03, 1'b1);
		readn(18'h0_0300, 3);
		rtx(1'b0);
		chk("zero", q, 18'h0_0300);
		readn(18'h0_0301, 1);
		mreset(1'b1, 1'b1, 1'b0);
		wr(18'h0_0400, 8'h03, 1'b1);
		for (k = 0; k < 12 && or_n !== 1'b0; k++) @(posedge i_clock);
		chk("or wait", 18'(or_n), 18'h0_0000);
		readn(18'h0_0401, 2);
		rtx(1'b0);
		chk("valid", 18'(or_n), 18'h0_0001);
		for (k = 0; k < 12 && or_n !== 1'b0; k++) @(posedge i_clock);
		#1;
		chk("or back", 18'(or_n), 18'h0_0000);
		chk("fall", q, 18'h0_0400);
		rd(1'b0);
		chk("first_word_fallthrough_mode ofs", q & 18'h0_FFFF, 18'h0_007F);
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge i_clock);
		err_total++;
		complete_run;
	end
endmodule
